// [logic/kbi_apb.sv]
// APB slave front end: decodes one-cycle write and read strobes
`timescale 1ns/10ps
module kbi_apb (
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic        ce_i,
  output logic             pready_o,
  output logic             wr_stb_o,
  output logic             rd_stb_o
);
  // Zero wait states, but a frozen block must not complete a transfer
  always_comb begin
    pready_o = ce_i;
    wr_stb_o = psel_i & penable_i & ce_i & pwrite_i;
    rd_stb_o = psel_i & penable_i & ce_i & ~pwrite_i;
  end
endmodule : kbi_apb

// [logic/kbi_pkg.sv]
// Types shared by the keypad interrupt block
package kbi_pkg;
  typedef struct packed {
    logic level_sense_select;
    logic keypad_irq_mask;
  } kbi_ctrl_t;

  typedef struct packed {
    logic       req;
    logic [15:0] vector;
  } kbi_cpu_req_t;
endpackage : kbi_pkg

// [logic/kbi_regs.svh]
// Register offsets, field positions, reset values, key count and vector for the keypad interrupt block
// Overview of operation
// (RULE_01) With level sensing selected, an enabled input requests on a falling edge and while held low.
// (RULE_02) A vector fetch acknowledge clears the pending keypad request as the sense mode allows.
// (RULE_03) Writing a one to the acknowledge bit gives the same acknowledge as a vector fetch.
// (RULE_04) An acknowledge write does not block later edges; a new falling edge latches a new request.
// (RULE_05) With the keypad mask clear and a request pending, the CPU is steered to the keypad vector.
// (RULE_06) In level mode the request stays set while any enabled input is low, even after acknowledge.
// (RULE_07) The auto-wakeup request clears only by an acknowledge write or by reset.
// (RULE_08) In level mode the request clears once acknowledge and all inputs high have both happened.
// (RULE_09) With level sensing off, inputs are falling-edge only and any acknowledge clears at once.
// (RULE_10) Reset clears the request and the level select bit even with an input held low.
// (RULE_11) A readable pending flag shows the request regardless of the mask.
// (RULE_12) With the mask set, requests are still latched and flagged but the CPU signal is withheld.
`ifndef KBI_REGS_SVH
`define KBI_REGS_SVH

`define KBI_ADDR_SCR        12'h000
`define KBI_ADDR_ENABLE     12'h004
`define KBI_ADDR_IRQ_STAT   12'h008
`define KBI_ADDR_IRQ_MASK   12'h00c

// Status/control bit positions
`define KBI_SCR_LEVEL       0
`define KBI_SCR_MASK        1
`define KBI_SCR_ACK         2
`define KBI_SCR_PEND        3
`define KBI_SCR_AWU         4

// Interrupt status bit positions
`define KBI_IST_KEY         0
`define KBI_IST_AWU         1

`define KBI_NUM_KEYS        6
`define KBI_VECTOR          16'hffe0
`define KBI_RST_SCR         5'h02
`define KBI_RST_ENABLE      6'h00
`define KBI_RST_IRQ         2'h0

`endif

// [logic/kbi_sync.sv]
// Two-flop synchroniser for the keypad pins
`timescale 1ns/10ps
`include "kbi_regs.svh"
module kbi_sync (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      ce_i,
  input  wire logic [`KBI_NUM_KEYS-1:0]  async_i,
  output logic      [`KBI_NUM_KEYS-1:0]  sync_o
);
  logic [`KBI_NUM_KEYS-1:0] meta;
  logic [`KBI_NUM_KEYS-1:0] next_meta;
  logic [`KBI_NUM_KEYS-1:0] next_sync;

  // Idle keys read high, so reset to ones to avoid a false edge
  always_comb begin
    next_meta = ce_i ? async_i : meta;
    next_sync = ce_i ? meta : sync_o;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      meta   <= {`KBI_NUM_KEYS{1'b1}};
      sync_o <= {`KBI_NUM_KEYS{1'b1}};
    end else begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end
endmodule : kbi_sync

// [logic/kbi_top.sv]
// Keypad interrupt request logic with APB registers and interrupt output
`timescale 1ns/10ps
`include "kbi_regs.svh"
module kbi_top (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     ce_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [11:0]              paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  input  wire logic [`KBI_NUM_KEYS-1:0] keypad_pins_i,
  input  wire logic                     auto_wakeup_event_i,
  input  wire logic                     vector_fetch_ack_i,
  output kbi_pkg::kbi_cpu_req_t         cpu_req_o,
  output logic                          irq_o
);
  logic                     wr_stb;
  logic                     rd_stb;
  logic [`KBI_NUM_KEYS-1:0] keys;

  kbi_apb u_apb (
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .ce_i      (ce_i),
    .pready_o  (pready_o),
    .wr_stb_o  (wr_stb),
    .rd_stb_o  (rd_stb)
  );

  kbi_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .async_i   (keypad_pins_i),
    .sync_o    (keys)
  );

  // Register and request state
  kbi_pkg::kbi_ctrl_t       ctrl;
  kbi_pkg::kbi_ctrl_t       next_ctrl;
  logic [`KBI_NUM_KEYS-1:0] key_enable;
  logic [`KBI_NUM_KEYS-1:0] next_key_enable;
  logic [`KBI_NUM_KEYS-1:0] keys_q;
  logic                     key_req;
  logic                     next_key_req;
  logic                     ack_seen;
  logic                     next_ack_seen;
  logic                     auto_wakeup_request;
  logic                     next_auto_wakeup_request;
  logic [1:0]               irq_stat;
  logic [1:0]               next_irq_stat;
  logic [1:0]               irq_mask;
  logic [1:0]               next_irq_mask;
  logic [31:0]              rdata;
  logic [31:0]              next_rdata;

  // Decoded helpers
  logic                     sw_ack;
  logic                     any_ack;
  logic                     edge_hit;
  logic                     any_low;
  logic                     keypad_pending_flag;
  logic                     key_set;
  logic                     mapped;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] b);
    addr_is = (a == b);
  endfunction : addr_is

  // Event and acknowledge decode
  always_comb begin
    sw_ack   = wr_stb & addr_is(paddr_i, `KBI_ADDR_SCR)
             & pwdata_i[`KBI_SCR_ACK];                               // RULE_03
    any_ack  = sw_ack | (ce_i & vector_fetch_ack_i);                 // RULE_02
    edge_hit = |(key_enable & keys_q & ~keys);                       // RULE_09
    any_low  = |(key_enable & ~keys);
    key_set  = edge_hit | (ctrl.level_sense_select & any_low);       // RULE_01
    mapped   = addr_is(paddr_i, `KBI_ADDR_SCR) | addr_is(paddr_i, `KBI_ADDR_ENABLE)
             | addr_is(paddr_i, `KBI_ADDR_IRQ_STAT) | addr_is(paddr_i, `KBI_ADDR_IRQ_MASK);
  end

  // Keypad request: set wins over acknowledge so no edge is lost
  always_comb begin
    next_key_req  = key_req;
    next_ack_seen = ack_seen;
    if (ce_i) begin
      if (!ctrl.level_sense_select) begin
        next_ack_seen = 1'b0;
        if (key_set) begin
          next_key_req = 1'b1;                                       // RULE_04
        end else if (any_ack) begin
          next_key_req = 1'b0;                                       // RULE_09
        end
      end else begin
        // Level mode: acknowledge and release may come in either order
        if (edge_hit) begin
          next_ack_seen = 1'b0;                                      // RULE_04
          next_key_req  = 1'b1;
        end else if (any_ack) begin
          next_ack_seen = key_req;
        end
        if (key_set) begin
          next_key_req = 1'b1;                                       // RULE_06
        end else if (key_req && (ack_seen || any_ack) && !edge_hit) begin
          next_key_req  = 1'b0;                                      // RULE_08
          next_ack_seen = 1'b0;
        end
        if (key_req && any_low && !edge_hit && any_ack) begin
          next_ack_seen = 1'b1;
        end
      end
    end
  end

  // Auto-wakeup request ignores vector fetches
  always_comb begin
    next_auto_wakeup_request = auto_wakeup_request;
    if (ce_i) begin
      if (auto_wakeup_event_i) begin
        next_auto_wakeup_request = 1'b1;
      end else if (sw_ack) begin
        next_auto_wakeup_request = 1'b0;                             // RULE_07
      end
    end
  end

  // Control, enable and interrupt registers
  always_comb begin
    next_ctrl       = ctrl;
    next_key_enable = key_enable;
    next_irq_mask   = irq_mask;
    next_irq_stat   = irq_stat;
    if (ce_i) begin
      if (wr_stb && addr_is(paddr_i, `KBI_ADDR_SCR)) begin
        next_ctrl.level_sense_select = pwdata_i[`KBI_SCR_LEVEL];
        next_ctrl.keypad_irq_mask    = pwdata_i[`KBI_SCR_MASK];
      end
      if (wr_stb && addr_is(paddr_i, `KBI_ADDR_ENABLE)) begin
        next_key_enable = pwdata_i[`KBI_NUM_KEYS-1:0];
      end
      if (wr_stb && addr_is(paddr_i, `KBI_ADDR_IRQ_MASK)) begin
        next_irq_mask = pwdata_i[1:0];
      end
      if (wr_stb && addr_is(paddr_i, `KBI_ADDR_IRQ_STAT)) begin
        next_irq_stat = irq_stat & ~pwdata_i[1:0];
      end
      // Sticky events set after the clear so a same-cycle event survives
      if (next_key_req && !key_req) begin
        next_irq_stat[`KBI_IST_KEY] = 1'b1;
      end
      if (auto_wakeup_event_i) begin
        next_irq_stat[`KBI_IST_AWU] = 1'b1;
      end
    end
  end

  // Read data mux, captured only on a read access
  always_comb begin
    keypad_pending_flag = key_req | auto_wakeup_request;            // RULE_11
    next_rdata = rdata;
    if (rd_stb) begin
      next_rdata = 32'h0000_0000;
      if (addr_is(paddr_i, `KBI_ADDR_SCR)) begin
        next_rdata[`KBI_SCR_LEVEL] = ctrl.level_sense_select;
        next_rdata[`KBI_SCR_MASK]  = ctrl.keypad_irq_mask;
        next_rdata[`KBI_SCR_PEND]  = keypad_pending_flag;
        next_rdata[`KBI_SCR_AWU]   = auto_wakeup_request;
      end else if (addr_is(paddr_i, `KBI_ADDR_ENABLE)) begin
        next_rdata[`KBI_NUM_KEYS-1:0] = key_enable;
      end else if (addr_is(paddr_i, `KBI_ADDR_IRQ_STAT)) begin
        next_rdata[1:0] = irq_stat;
      end else if (addr_is(paddr_i, `KBI_ADDR_IRQ_MASK)) begin
        next_rdata[1:0] = irq_mask;
      end
    end
  end

  // Read data is combinationally steered since pready is zero-wait
  always_comb begin
    prdata_o  = next_rdata;
    pslverr_o = psel_i & penable_i & ~mapped;
  end

  // CPU request withheld while masked, flag still visible
  always_comb begin
    cpu_req_o.req    = keypad_pending_flag & ~ctrl.keypad_irq_mask;  // RULE_12
    cpu_req_o.vector = `KBI_VECTOR;                                  // RULE_05
    irq_o            = |(irq_stat & irq_mask);
  end

  // State registers; reset clears request and level select
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ctrl                <= kbi_pkg::kbi_ctrl_t'(2'b01);            // RULE_10
      key_enable          <= `KBI_RST_ENABLE;
      keys_q              <= {`KBI_NUM_KEYS{1'b1}};
      key_req             <= 1'b0;                                   // RULE_10
      ack_seen            <= 1'b0;
      auto_wakeup_request <= 1'b0;                                   // RULE_07
      irq_stat            <= `KBI_RST_IRQ;
      irq_mask            <= `KBI_RST_IRQ;
      rdata               <= 32'h0000_0000;
    end else begin
      ctrl                <= next_ctrl;
      key_enable          <= next_key_enable;
      keys_q              <= ce_i ? keys : keys_q;
      key_req             <= next_key_req;
      ack_seen            <= next_ack_seen;
      auto_wakeup_request <= next_auto_wakeup_request;
      irq_stat            <= next_irq_stat;
      irq_mask            <= next_irq_mask;
      rdata               <= next_rdata;
    end
  end
endmodule : kbi_top

// [test/kbi_cpu_model.sv]
// Keypad switches and CPU vector fetch model
`timescale 1ns/10ps
module kbi_cpu_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       req_i,
  input  wire logic       auto_i,
  input  wire logic [3:0] delay_i,
  input  wire logic [5:0] keys_i,
  output logic      [5:0] pins_o,
  output logic            ack_o
);
  logic [3:0] cnt;
  initial {pins_o, ack_o, cnt} = {6'h3f, 1'b0, 4'h0};
  // Fetch after a chosen latency; keeps refetching while the request stands
  always @(posedge sys_clk_i) begin
    pins_o <= keys_i;
    ack_o  <= 1'b0;
    if (!rst_b_i || !auto_i || !req_i) begin
      cnt <= 4'h0;
    end else if (cnt == delay_i) begin
      ack_o <= 1'b1;
      cnt   <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : kbi_cpu_model

// [test/kbi_props.sv]
// Port-level checker for the keypad interrupt block
`timescale 1ns/10ps
module kbi_props (
  input wire logic                  sys_clk_i,
  input wire logic                  rst_b_i,
  input wire logic                  ce_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pwrite_i,
  input wire logic [11:0]           paddr_i,
  input wire logic [31:0]           pwdata_i,
  input wire logic                  pslverr_o,
  input wire logic [5:0]            keypad_pins_i,
  input wire logic                  auto_wakeup_event_i,
  input wire logic                  vector_fetch_ack_i,
  input wire kbi_pkg::kbi_cpu_req_t cpu_req_o,
  input wire logic                  irq_o
);
  logic       lvl, msk, awu, wr, ack_w, hi;
  logic [5:0] en;
  logic [1:0] im;
  assign wr    = psel_i && penable_i && pwrite_i && ce_i;
  assign ack_w = wr && paddr_i == 12'h000 && pwdata_i[2];
  assign hi    = &(keypad_pins_i | ~en);
  // Shadow of control bits; awu clears only on reset so later checks stay safe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      {lvl, msk, awu, en, im} <= {3'h2, 6'h00, 2'h0};
    end else begin
      if (wr && paddr_i == 12'h000) {msk, lvl} <= pwdata_i[1:0];
      if (wr && paddr_i == 12'h004) en <= pwdata_i[5:0];
      if (wr && paddr_i == 12'h00c) im <= pwdata_i[1:0];
      if (auto_wakeup_event_i && ce_i) awu <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_keys_up;
    (hi && !lvl && !awu && ce_i)[*4];
  endsequence
  sequence s_keys_down;
    (!hi && lvl && !msk && ce_i)[*4];
  endsequence
  chk_vec_fixed: assert property (cpu_req_o.req |-> cpu_req_o.vector == 16'hffe0)
    else $error("vector wrong while request up");
  chk_mask_hold: assert property (msk |-> !cpu_req_o.req)
    else $error("request seen while masked");
  chk_edge_ack: assert property (s_keys_up ##0 (vector_fetch_ack_i || ack_w)
    |=> !cpu_req_o.req) else $error("edge request not cleared");
  chk_level_hold: assert property (s_keys_down ##0 (vector_fetch_ack_i
    || (ack_w && pwdata_i[1:0] == 2'h1)) |=> cpu_req_o.req) else $error("level request lost");
  chk_level_clr: assert property ((hi && lvl && !awu && ce_i)[*5] ##0
    (ack_w && pwdata_i[1:0] == 2'h1) |=> !cpu_req_o.req) else $error("level request stuck");
  chk_awu_keep: assert property (auto_wakeup_event_i && ce_i ##1 (!msk && !ack_w)[*4]
    |-> cpu_req_o.req) else $error("wakeup request lost");
  chk_awu_irq: assert property (auto_wakeup_event_i && ce_i && im[1] |=> irq_o)
    else $error("unmasked event gave no interrupt");
  chk_bad_addr: assert property (psel_i && penable_i && ce_i && paddr_i > 12'h00c |-> pslverr_o)
    else $error("unmapped access not flagged");
  chk_reset_clr: assert property (disable iff (1'b0) !rst_b_i |=> !cpu_req_o.req && !irq_o)
    else $error("reset left a request");
endmodule : kbi_props

// [test/tb.sv]
// Self-checking bench for the keypad interrupt block
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        pready, pslverr, irq, vack, awu_ev = 1'b0, auto = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'hb940cd70;
  logic [5:0]  pins, keys = 6'h3f;
  logic [3:0]  dly = 4'h0;
  logic [34:0] exp_q[$];
  int          err_count = 0, compares = 0, cyc = 0;
  kbi_pkg::kbi_cpu_req_t creq;
  always #2.5 clk = ~clk;
  kbi_top i_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .keypad_pins_i(pins), .auto_wakeup_event_i(awu_ev),
    .vector_fetch_ack_i(vack), .cpu_req_o(creq), .irq_o(irq));
  kbi_cpu_model i_cpu (.sys_clk_i(clk), .rst_b_i(rst_b), .req_i(creq.req), .auto_i(auto),
    .delay_i(dly), .keys_i(keys), .pins_o(pins), .ack_o(vack));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Expected read snapshot is {irq, req, slverr, data}; queued before the access edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [34:0] e);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    if (!w) exp_q.push_back(e);
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // Each completed read retires the oldest expectation
  always @(posedge clk) begin
    if (psel && pen && pready && !pwr && exp_q.size() > 0)
      check({irq, creq.req, pslverr, prdata}, exp_q.pop_front());
  end
  // Run ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    wt(5);
    rst_b <= 1'b1;
    wt(1);
    apb(0, 12'h000, 0, {3'b000, 32'h02});
    apb(0, 12'h010, 0, {3'b001, 32'h0});
    r = rnd();
    apb(1, 12'h004, r | 32'h1, 0);
    apb(0, 12'h004, 0, {3'b000, 26'h0, r[5:0] | 6'h01});
    apb(1, 12'h00c, 32'h3, 0);
    apb(1, 12'h000, 32'h0, 0);
    // Edge mode: ack clears even with the key still down
    keys <= 6'h3e;
    wt(6);
    apb(0, 12'h000, 0, {3'b110, 32'h08});
    apb(1, 12'h000, 32'h4, 0);
    apb(0, 12'h000, 0, {3'b100, 32'h00});
    apb(1, 12'h008, 32'h1, 0);
    keys <= 6'h3f;
    wt(6);
    keys <= 6'h3e;
    wt(6);
    apb(0, 12'h000, 0, {3'b110, 32'h08});
    keys <= 6'h3f;
    r = rnd();
    // Fetch no sooner than four cycles so the keys are settled high before the ack
    dly <= r[3:0] | 4'h4;
    auto <= 1'b1;
    wt(24);
    auto <= 1'b0;
    apb(0, 12'h000, 0, {3'b100, 32'h00});
    apb(1, 12'h008, 32'h1, 0);
    // Level mode, both orders of ack and release
    apb(1, 12'h000, 32'h1, 0);
    keys <= 6'h3e;
    wt(6);
    apb(1, 12'h000, 32'h5, 0);
    apb(0, 12'h000, 0, {3'b110, 32'h09});
    keys <= 6'h3f;
    wt(6);
    apb(0, 12'h000, 0, {3'b100, 32'h01});
    keys <= 6'h3e;
    wt(6);
    keys <= 6'h3f;
    wt(6);
    apb(0, 12'h000, 0, {3'b110, 32'h09});
    apb(1, 12'h000, 32'h5, 0);
    apb(0, 12'h000, 0, {3'b100, 32'h01});
    apb(1, 12'h008, 32'h1, 0);
    apb(1, 12'h000, 32'h3, 0);
    keys <= 6'h3e;
    wt(6);
    apb(0, 12'h000, 0, {3'b100, 32'h0b});
    rst_b <= 1'b0;
    wt(2);
    rst_b <= 1'b1;
    wt(1);
    // Frozen block must stall the access until enable returns
    ce <= 1'b0;
    fork
      apb(0, 12'h000, 0, {3'b000, 32'h02});
      begin
        wt(4);
        ce <= 1'b1;
      end
    join
    // Wakeup survives vector fetches, then masked and cleared
    keys <= 6'h3f;
    apb(1, 12'h000, 32'h0, 0);
    apb(1, 12'h00c, 32'h2, 0);
    awu_ev <= 1'b1;
    wt(1);
    awu_ev <= 1'b0;
    auto <= 1'b1;
    wt(24);
    auto <= 1'b0;
    apb(0, 12'h000, 0, {3'b110, 32'h18});
    apb(1, 12'h00c, 32'h0, 0);
    apb(0, 12'h008, 0, {3'b010, 32'h02});
    apb(1, 12'h008, 32'h2, 0);
    apb(1, 12'h000, 32'h4, 0);
    apb(0, 12'h000, 0, {3'b000, 32'h00});
    complete_run();
  end
endmodule : tb
bind kbi_top kbi_props i_props (.sys_clk_i, .rst_b_i, .ce_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pslverr_o, .keypad_pins_i, .auto_wakeup_event_i, .vector_fetch_ack_i,
  .cpu_req_o, .irq_o);
